// file: hw/csfo_frame_tx.sv
`timescale 1ns/1ps
module csfo_frame_tx
   import csfo_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_start,
   input wire csfo_hdr_t i_hdr,
   input wire logic i_ready,
   output logic o_busy,
   output csfo_tx_t o_tx
);

   logic [2:0] idx_ff;
   csfo_hdr_t hdr_ff;
   logic adv;

   assign adv = o_tx.valid & i_ready;
   assign o_busy = o_tx.valid;

   function automatic logic [7:0] frame_byte(input logic [2:0] i, input csfo_hdr_t h);
      logic [7:0] b;
      b = 8'h00;
      unique case (i)
         3'h0: b = {h.level, CSF_VERSION};
         3'h1: b = CSF_OPCODE;
         3'h2: b = {1'b0, h.ctype, h.period, 1'b0};
         3'h3: b = CSF_TLV_OFS;
         default: b = CSF_END_TLV;
      endcase
      return b;
   endfunction

   // ----------------------------------------
   // byte serialiser, stalls on ready low
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         idx_ff <= 3'h0;
         hdr_ff <= '0;
         o_tx <= '0;
      end
      else if (i_start && !o_tx.valid)
      begin
         idx_ff <= 3'h0;
         hdr_ff <= i_hdr;
         o_tx.valid <= 1'b1;
         o_tx.sof <= 1'b1;
         o_tx.eof <= 1'b0;
         o_tx.data <= frame_byte(3'h0, i_hdr);
         o_tx.prio <= i_hdr.prio;
         o_tx.dei <= 1'b0;
      end
      else if (adv)
      begin
         if (o_tx.eof)
         begin
            o_tx <= '0;
         end
         else
         begin
            idx_ff <= idx_ff + 3'h1;
            o_tx.sof <= 1'b0;
            o_tx.eof <= (idx_ff + 3'h1) == CSF_LAST_IDX;
            o_tx.data <= frame_byte(idx_ff + 3'h1, hdr_ff);
         end
      end
   end

endmodule

// file: hw/csfo_ms_tick.sv
`timescale 1ns/1ps
module csfo_ms_tick
   import csfo_pkg::*;
#(
   parameter int unsigned P_CYC_PER_MS = CYC_PER_MS
)
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   output logic o_tick_ff
);

   localparam int unsigned CW = $clog2(P_CYC_PER_MS + 1);
   logic [CW-1:0] cnt_ff;

   // ----------------------------------------
   // millisecond prescaler
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         cnt_ff <= '0;
         o_tick_ff <= 1'b0;
      end
      else if (cnt_ff == CW'(P_CYC_PER_MS - 1))
      begin
         cnt_ff <= '0;
         o_tick_ff <= 1'b1;
      end
      else
      begin
         cnt_ff <= cnt_ff + 1'b1;
         o_tick_ff <= 1'b0;
      end
   end

endmodule

// file: hw/csfo_pkg.sv
// Behaviour
// - client fault starts fault frames immediately
// - no fault frames without a client fault
// - periodic frames continue until link up
// - on clearance stop or send one clear
// - per end point enable gates all frames
// - non-clear fault frame declares remote fault
// - no frame within 3.5 periods clears
// - clear-type frame clears remote fault at once
// - egress port down while remote fault
// - continuity loss brings egress port up
// - frame carries 3-bit maintenance level
// - version 0, opcode 52
// - flags 6:4 carry the fault type
// - flags 3:1 carry the period code
// - tlv offset zero, end tlv zero
// - frames only while end point up
// - aggregate member cannot be bound
// - aggregate link down faults like physical
// - events on raise, clear-by-frame, clear-by-timeout
// - period defaults to one second
// - frames drop-ineligible, configured priority
package csfo_pkg;

   // ----------------------------------------
   // clocking and timing
   // ----------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned MS_IN_NS = 1000000;
   localparam int unsigned CYC_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
   localparam int unsigned MS_W = 18;
   localparam logic [17:0] PERIOD_1S_MS = 18'h003E8;
   localparam logic [17:0] PERIOD_1M_MS = 18'h0EA60;
   localparam int unsigned TMO_NUM = 7;
   localparam int unsigned TMO_DEN = 2;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_EVENT = 4'h8;
   localparam int unsigned CTRL_TXEN = 0;
   localparam int unsigned CTRL_DCI = 1;
   localparam int unsigned CTRL_PMIN = 2;
   localparam int unsigned CTRL_LVL_LSB = 4;
   localparam int unsigned CTRL_TYPE_LSB = 8;
   localparam int unsigned CTRL_PRIO_LSB = 12;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;

   // ----------------------------------------
   // frame layout
   // ----------------------------------------
   localparam logic [4:0] CSF_VERSION = 5'h00;
   localparam logic [7:0] CSF_OPCODE = 8'h34;
   localparam logic [7:0] CSF_TLV_OFS = 8'h00;
   localparam logic [7:0] CSF_END_TLV = 8'h00;
   localparam logic [2:0] CSF_LAST_IDX = 3'h4;
   localparam int unsigned FLAG_TYPE_LSB = 4;
   localparam int unsigned FLAG_PER_LSB = 1;
   localparam logic [2:0] TYPE_LOS = 3'h0;
   localparam logic [2:0] TYPE_FDI = 3'h1;
   localparam logic [2:0] TYPE_RDI = 3'h2;
   localparam logic [2:0] TYPE_DCI = 3'h3;
   localparam logic [2:0] PER_1S = 3'h4;
   localparam logic [2:0] PER_1M = 3'h6;

   typedef struct packed {
      logic valid;
      logic sof;
      logic eof;
      logic [7:0] data;
      logic [2:0] prio;
      logic dei;
   } csfo_tx_t;

   typedef struct packed {
      logic valid;
      logic sof;
      logic eof;
      logic [7:0] data;
   } csfo_rx_t;

   typedef struct packed {
      logic raise;
      logic clr_dci;
      logic clr_tmo;
   } csfo_evt_t;

   typedef struct packed {
      logic [2:0] level;
      logic [2:0] ctype;
      logic [2:0] period;
      logic [2:0] prio;
   } csfo_hdr_t;

   function automatic logic [17:0] csfo_period_ms(input logic [2:0] code);
      return (code == PER_1M) ? PERIOD_1M_MS : PERIOD_1S_MS;
   endfunction

   function automatic logic [17:0] csfo_tmo_ms(input logic [2:0] code);
      logic [19:0] t;
      t = 20'(csfo_period_ms(code)) * 20'(TMO_NUM) / 20'(TMO_DEN);
      return t[17:0];
   endfunction

endpackage

// file: hw/csfo_top.sv
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module csfo_top
   import csfo_pkg::*;
#(
   parameter int unsigned P_CYC_PER_MS = CYC_PER_MS
)
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_phys_link_up,
   input wire logic i_client_is_lag,
   input wire logic i_lag_link_up,
   input wire logic i_phys_is_lag_member,
   input wire logic i_mep_up,
   input wire logic i_rmep_ok,
   input wire csfo_rx_t i_rx,
   input wire logic i_tx_ready,
   output logic [31:0] o_rdata_ff,
   output csfo_tx_t o_tx,
   output logic o_egress_down_ff,
   output csfo_evt_t o_evt_ff
);

   typedef enum logic [0:0] {TX_IDLE, TX_ACTIVE} csfo_txst_t;

   logic [31:0] ctrl_ff;
   logic [2:0] evt_sticky_ff;
   logic bound_ff;
   logic fault_ff;
   csfo_txst_t tx_st_ff;
   csfo_txst_t nxt_tx_st;
   logic [MS_W-1:0] tx_ms_ff;
   logic [MS_W-1:0] nxt_tx_ms;
   logic pend_ff;
   logic pend_dci_ff;
   logic nxt_req;
   logic nxt_req_dci;
   logic tick;
   logic tx_busy;
   logic tx_start;
   logic allowed;
   logic client_up;
   csfo_hdr_t hdr;
   logic [7:0] rx_b_ff [0:3];
   logic [2:0] rx_idx_ff;
   logic rx_inframe_ff;
   logic rx_good;
   logic [2:0] rx_type;
   logic [2:0] rx_per;
   logic rfault_ff;
   logic [MS_W-1:0] rx_tmo_ff;
   logic tmo_hit;

   // ----------------------------------------
   // register port
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         ctrl_ff <= CTRL_RST;
      end
      else if (i_wr && i_addr == REG_CTRL)
      begin
         ctrl_ff <= i_wdata;
      end
   end

   // set wins over the write-one clear so no event is lost
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         evt_sticky_ff <= 3'h0;
      end
      else
      begin
         evt_sticky_ff <= (evt_sticky_ff & ~((i_wr && i_addr == REG_EVENT) ?
            i_wdata[2:0] : 3'h0)) | {o_evt_ff.clr_tmo, o_evt_ff.clr_dci, o_evt_ff.raise};
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_rdata_ff <= 32'h0000_0000;
      end
      else if (i_rd)
      begin
         unique case (i_addr)
            REG_CTRL: o_rdata_ff <= ctrl_ff;
            REG_STATUS: o_rdata_ff <= {26'h0, i_mep_up, bound_ff, o_egress_down_ff,
               tx_st_ff == TX_ACTIVE, rfault_ff, fault_ff};
            REG_EVENT: o_rdata_ff <= {29'h0, evt_sticky_ff};
            default: o_rdata_ff <= 32'h0000_0000;
         endcase
      end
      else
      begin
         o_rdata_ff <= 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // client port monitoring
   // ----------------------------------------
   assign client_up = i_client_is_lag ? i_lag_link_up : i_phys_link_up;

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         bound_ff <= 1'b0;
         fault_ff <= 1'b0;
      end
      else
      begin
         // a member port is never a valid client, so it never faults
         bound_ff <= i_client_is_lag || !i_phys_is_lag_member;
         fault_ff <= bound_ff && !client_up;
      end
   end

   // ----------------------------------------
   // transmit sequencing
   // ----------------------------------------
   assign allowed = ctrl_ff[CTRL_TXEN] && i_mep_up && bound_ff;

   always_comb
   begin
      nxt_tx_st = tx_st_ff;
      nxt_tx_ms = tx_ms_ff;
      nxt_req = 1'b0;
      nxt_req_dci = 1'b0;
      unique case (tx_st_ff)
         TX_IDLE:
         begin
            if (allowed && fault_ff)
            begin
               nxt_tx_st = TX_ACTIVE;
               nxt_req = 1'b1;
               nxt_tx_ms = csfo_period_ms(hdr.period) - 18'h00001;
            end
         end
         TX_ACTIVE:
         begin
            if (!allowed)
            begin
               nxt_tx_st = TX_IDLE;
            end
            else if (!fault_ff)
            begin
               nxt_tx_st = TX_IDLE;
               nxt_req = ctrl_ff[CTRL_DCI];
               nxt_req_dci = 1'b1;
            end
            else if (tick)
            begin
               if (tx_ms_ff == '0)
               begin
                  nxt_req = 1'b1;
                  nxt_tx_ms = csfo_period_ms(hdr.period) - 18'h00001;
               end
               else
               begin
                  nxt_tx_ms = tx_ms_ff - 18'h00001;
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         tx_st_ff <= TX_IDLE;
         tx_ms_ff <= '0;
      end
      else
      begin
         tx_st_ff <= nxt_tx_st;
         tx_ms_ff <= nxt_tx_ms;
      end
   end

   // a request waits for the serialiser; losing the enable drops it
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         pend_ff <= 1'b0;
         pend_dci_ff <= 1'b0;
      end
      else if (!allowed)
      begin
         pend_ff <= 1'b0;
         pend_dci_ff <= 1'b0;
      end
      else if (nxt_req)
      begin
         pend_ff <= 1'b1;
         pend_dci_ff <= nxt_req_dci;
      end
      else if (tx_start)
      begin
         pend_ff <= 1'b0;
      end
   end

   assign tx_start = pend_ff && !tx_busy && allowed && (fault_ff || pend_dci_ff);
   assign hdr.level = ctrl_ff[CTRL_LVL_LSB +: 3];
   assign hdr.ctype = pend_dci_ff ? TYPE_DCI : ctrl_ff[CTRL_TYPE_LSB +: 3];
   assign hdr.period = ctrl_ff[CTRL_PMIN] ? PER_1M : PER_1S;
   assign hdr.prio = ctrl_ff[CTRL_PRIO_LSB +: 3];

   csfo_ms_tick #(
      .P_CYC_PER_MS(P_CYC_PER_MS)
   ) u_tick (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .o_tick_ff(tick)
   );

   csfo_frame_tx u_ftx (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_start(tx_start),
      .i_hdr(hdr),
      .i_ready(i_tx_ready),
      .o_busy(tx_busy),
      .o_tx(o_tx)
   );

   // ----------------------------------------
   // receive parsing
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rx_idx_ff <= 3'h0;
         rx_inframe_ff <= 1'b0;
         for (int i = 0; i < 4; i++)
         begin
            rx_b_ff[i] <= 8'h00;
         end
      end
      else if (i_rx.valid)
      begin
         if (i_rx.sof)
         begin
            rx_b_ff[0] <= i_rx.data;
            rx_idx_ff <= 3'h1;
            rx_inframe_ff <= !i_rx.eof;
         end
         else if (rx_inframe_ff)
         begin
            if (rx_idx_ff < CSF_LAST_IDX)
            begin
               rx_b_ff[rx_idx_ff[1:0]] <= i_rx.data;
            end
            rx_idx_ff <= (rx_idx_ff == 3'h7) ? rx_idx_ff : rx_idx_ff + 3'h1;
            rx_inframe_ff <= !i_rx.eof;
         end
      end
   end

   // spare flag bits 7 and 0 are not looked at
   assign rx_type = rx_b_ff[2][FLAG_TYPE_LSB +: 3];
   assign rx_per = rx_b_ff[2][FLAG_PER_LSB +: 3];
   assign rx_good = i_rx.valid && i_rx.eof && !i_rx.sof && rx_inframe_ff
      && rx_idx_ff == CSF_LAST_IDX
      && rx_b_ff[0] == {ctrl_ff[CTRL_LVL_LSB +: 3], CSF_VERSION}
      && rx_b_ff[1] == CSF_OPCODE
      && (rx_per == PER_1S || rx_per == PER_1M)
      && rx_b_ff[3] == CSF_TLV_OFS && i_rx.data == CSF_END_TLV;

   // ----------------------------------------
   // remote fault condition
   // ----------------------------------------
   assign tmo_hit = rfault_ff && tick && rx_tmo_ff == '0;

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rfault_ff <= 1'b0;
         rx_tmo_ff <= '0;
      end
      else if (!i_rmep_ok)
      begin
         rfault_ff <= 1'b0;
      end
      else if (rx_good && rx_type != TYPE_DCI)
      begin
         rfault_ff <= 1'b1;
         rx_tmo_ff <= csfo_tmo_ms(rx_per) - 18'h00001;
      end
      else if (rx_good)
      begin
         rfault_ff <= 1'b0;
      end
      else if (tmo_hit)
      begin
         rfault_ff <= 1'b0;
      end
      else if (tick && rx_tmo_ff != '0)
      begin
         rx_tmo_ff <= rx_tmo_ff - 18'h00001;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_egress_down_ff <= 1'b0;
         o_evt_ff <= '0;
      end
      else
      begin
         o_egress_down_ff <= rfault_ff;
         o_evt_ff.raise <= i_rmep_ok && rx_good && rx_type != TYPE_DCI && !rfault_ff;
         o_evt_ff.clr_dci <= i_rmep_ok && rx_good && rx_type == TYPE_DCI && rfault_ff;
         o_evt_ff.clr_tmo <= i_rmep_ok && !rx_good && tmo_hit;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);

   AST_NO_FRAME_NO_FAULT: assert property (tx_start && !pend_dci_ff |-> fault_ff)
      else $error("fault frame started without client fault");
   AST_START_ON_FAULT: assert property (
      tx_st_ff == TX_IDLE && fault_ff && allowed |=> pend_ff && tx_st_ff == TX_ACTIVE)
      else $error("fault did not request a frame");
   AST_TX_ENABLED: assert property (tx_start |-> ctrl_ff[CTRL_TXEN] && i_mep_up)
      else $error("frame started while disabled");
   AST_MEP_DOWN_IDLE: assert property (!i_mep_up |=> tx_st_ff == TX_IDLE && !pend_ff)
      else $error("transmission kept while end point down");
   AST_REMOTE_SET: assert property (
      i_rmep_ok && rx_good && rx_type != TYPE_DCI |=> rfault_ff ##1 o_egress_down_ff)
      else $error("remote fault not declared");
   AST_REMOTE_DCI: assert property (
      i_rmep_ok && rx_good && rx_type == TYPE_DCI |=> !rfault_ff ##1 !o_egress_down_ff)
      else $error("clear frame did not clear");
   AST_RMEP_FAIL_UP: assert property (!i_rmep_ok |=> !rfault_ff ##1 !o_egress_down_ff)
      else $error("egress kept down after continuity loss");
   AST_TMO_CLEAR: assert property (tmo_hit && i_rmep_ok && !rx_good
      |=> !rfault_ff && o_evt_ff.clr_tmo)
      else $error("timeout did not clear remote fault");
   AST_EGRESS_FOLLOWS: assert property (##1 o_egress_down_ff == $past(rfault_ff))
      else $error("egress state does not follow remote fault");
   AST_DEI_ZERO: assert property (o_tx.valid
      |-> !o_tx.dei && (!$rose(o_tx.valid) || o_tx.prio == $past(hdr.prio)))
      else $error("frame drop eligible or wrong priority");

   COV_FAULT_FRAME: cover property (tx_start && !pend_dci_ff);
   COV_DCI_FRAME: cover property (tx_start && pend_dci_ff);
   COV_REMOTE_RAISE: cover property (o_evt_ff.raise);
   COV_TMO_CLEAR: cover property (o_evt_ff.clr_tmo);

endmodule

// file: verif/csfo_peer_model.sv
`timescale 1ns/1ps
// --------------------------------
// far-side end point: frame sink and frame source
// --------------------------------
module csfo_peer_model
   import csfo_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire csfo_tx_t i_tx,
   input wire logic i_slow,
   output logic o_ready,
   output csfo_rx_t o_rx
);
   logic [7:0] frame_q[$];
   int n_frames = 0;
   logic [2:0] last_prio;
   logic last_dei;
   logic [1:0] stall_ff;

   // slow sink accepts one cycle in four
   always_ff @(posedge i_clk or negedge i_rst_b)
      if (!i_rst_b)
         stall_ff <= 2'h0;
      else
         stall_ff <= stall_ff + 2'h1;
   assign o_ready = !i_slow || (stall_ff == 2'h3);

   always @(posedge i_clk)
      if (i_tx.valid && o_ready)
      begin
         if (i_tx.sof)
            frame_q.delete();
         frame_q.push_back(i_tx.data);
         last_prio = i_tx.prio;
         last_dei = i_tx.dei;
         if (i_tx.eof)
            n_frames <= n_frames + 1;
      end

   initial o_rx = '{1'b0, 1'b0, 1'b0, 8'h5A};

   // level byte, opcode, flags, tlv offset, end tlv
   task automatic send(input logic [2:0] lvl, input logic [7:0] flags);
      logic [7:0] pdu[5];
      pdu = '{{lvl, CSF_VERSION}, CSF_OPCODE, flags, CSF_TLV_OFS, CSF_END_TLV};
      for (int k = 0; k < 5; k++)
      begin
         @(posedge i_clk);
         o_rx <= '{1'b1, k == 0, k == 4, pdu[k]};
      end
      @(posedge i_clk);
      // released line shows the inverse, never the stale byte
      o_rx <= '{1'b0, 1'b0, 1'b0, ~pdu[4]};
   endtask
endmodule

// file: verif/csfo_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin errors++; \
   $display("wrong value %s exp %0h got %0h", nm, ex, gt); end end
module csfo_top_tb
   import csfo_pkg::*;
;
   localparam int unsigned CPM = 10;
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic phys_up = 1'b1;
   logic is_lag = 1'b0;
   logic lag_up = 1'b1;
   logic member = 1'b0;
   logic mep_up = 1'b1;
   logic rmep_ok = 1'b1;
   logic slow = 1'b0;
   logic tx_ready;
   csfo_rx_t rx;
   csfo_tx_t tx;
   logic [31:0] rdata;
   logic egr_down;
   csfo_evt_t evt;
   int errors = 0;
   int cmp_count = 0;
   int n_raise = 0;
   int n_dci = 0;
   int n_tmo = 0;
   logic [31:0] d;
   int c;

   always #10 i_clk = ~i_clk;

   csfo_top #(.P_CYC_PER_MS(CPM)) i_csfo_top (.i_clk(i_clk), .i_rst_b(i_rst_b),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .i_phys_link_up(phys_up), .i_client_is_lag(is_lag), .i_lag_link_up(lag_up),
      .i_phys_is_lag_member(member), .i_mep_up(mep_up), .i_rmep_ok(rmep_ok),
      .i_rx(rx), .i_tx_ready(tx_ready), .o_rdata_ff(rdata), .o_tx(tx),
      .o_egress_down_ff(egr_down), .o_evt_ff(evt));

   csfo_peer_model i_csfo_peer_model (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_tx(tx),
      .i_slow(slow), .o_ready(tx_ready), .o_rx(rx));

   always @(posedge i_clk)
   begin
      n_raise += int'(evt.raise === 1'b1);
      n_dci += int'(evt.clr_dci === 1'b1);
      n_tmo += int'(evt.clr_tmo === 1'b1);
   end

   // --------------------------------
   // access tasks
   // --------------------------------
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic wait_frame(input int lim, output int cyc);
      int n0;
      n0 = i_csfo_peer_model.n_frames;
      cyc = 0;
      while (i_csfo_peer_model.n_frames == n0 && cyc < lim)
      begin
         @(posedge i_clk);
         cyc++;
      end
   endtask

   task automatic chk_frame(input logic [2:0] ty, input logic [2:0] pe);
      logic [7:0] ex[5];
      ex = '{{3'h5, CSF_VERSION}, CSF_OPCODE, {1'b0, ty, pe, 1'b0}, CSF_TLV_OFS, CSF_END_TLV};
      `CHK("frame length", 32'h5, 32'(i_csfo_peer_model.frame_q.size()))
      for (int k = 0; k < 5; k++)
         `CHK("frame byte", ex[k], i_csfo_peer_model.frame_q[k])
   endtask

   task automatic rx_frame(input logic [7:0] flags);
      i_csfo_peer_model.send(3'h5, flags);
      repeat (3) @(posedge i_clk);
   endtask

   task automatic finish_test;
      $display("TB: errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // --------------------------------
   // test sequence
   // --------------------------------
   initial
   begin
      repeat (2) @(posedge i_clk);
      i_rst_b <= 1'b1;
      rd(REG_CTRL, d);
      `CHK("ctrl reset", 32'h0, d)
      rd(4'hC, d);
      `CHK("unmapped", 32'h0, d)
      phys_up <= 1'b0;
      wait_frame(60, c);
      `CHK("disabled quiet", 60, c)
      phys_up <= 1'b1;
      // one frame per fault type and period code, stalling sink on the last
      for (int t = 0; t < 3; t++)
      begin
         wr(REG_CTRL, 32'h1 | (32'(t[0]) << CTRL_PMIN) | (32'h5 << CTRL_LVL_LSB)
            | (32'(t) << CTRL_TYPE_LSB) | (32'h6 << CTRL_PRIO_LSB));
         slow <= t[1];
         phys_up <= 1'b0;
         wait_frame(60, c);
         `CHK("prompt frame", 1'b1, c < 60)
         chk_frame(3'(t), t[0] ? PER_1M : PER_1S);
         `CHK("prio", 3'h6, i_csfo_peer_model.last_prio)
         `CHK("dei", 1'b0, i_csfo_peer_model.last_dei)
         phys_up <= 1'b1;
         repeat (10) @(posedge i_clk);
      end
      slow <= 1'b0;
      // periodic frames at default period, then one clear frame, then silence
      wr(REG_CTRL, 32'h3 | (32'h5 << CTRL_LVL_LSB));
      phys_up <= 1'b0;
      wait_frame(60, c);
      wait_frame(10100, c);
      `CHK("period", 1'b1, c > 9980 && c < 10020)
      phys_up <= 1'b1;
      wait_frame(60, c);
      chk_frame(TYPE_DCI, PER_1S);
      wait_frame(10100, c);
      `CHK("no fault quiet", 10100, c)
      // end point down, then bound to an aggregate member
      for (int g = 0; g < 2; g++)
      begin
         mep_up <= g[0];
         member <= g[0];
         @(posedge i_clk);
         phys_up <= 1'b0;
         wait_frame(60, c);
         `CHK("gated quiet", 60, c)
         phys_up <= 1'b1;
         repeat (10) @(posedge i_clk);
      end
      mep_up <= 1'b1;
      member <= 1'b0;
      is_lag <= 1'b1;
      lag_up <= 1'b0;
      wait_frame(60, c);
      `CHK("aggregate fault", 1'b1, c < 60)
      lag_up <= 1'b1;
      repeat (10) @(posedge i_clk);
      // receive side, spare flag bit set on the first frame
      rx_frame({1'b0, TYPE_LOS, PER_1S, 1'b1});
      `CHK("egress down", 1'b1, egr_down)
      `CHK("raise events", 1, n_raise)
      rd(REG_STATUS, d);
      `CHK("status", 32'h3A, d)
      rd(REG_EVENT, d);
      `CHK("event reg", 3'h1, d[2:0])
      wr(REG_EVENT, 32'h7);
      rd(REG_EVENT, d);
      `CHK("event cleared", 3'h0, d[2:0])
      rx_frame({1'b0, TYPE_DCI, PER_1S, 1'b0});
      `CHK("egress up", 1'b0, egr_down)
      `CHK("clear events", 1, n_dci)
      rx_frame({1'b0, TYPE_FDI, PER_1S, 1'b0});
      repeat (34900) @(posedge i_clk);
      `CHK("held before timeout", 1'b1, egr_down)
      repeat (200) @(posedge i_clk);
      `CHK("timeout clear", 1'b0, egr_down)
      `CHK("timeout events", 1, n_tmo)
      rx_frame({1'b0, TYPE_RDI, PER_1S, 1'b0});
      `CHK("egress down again", 1'b1, egr_down)
      rmep_ok <= 1'b0;
      repeat (3) @(posedge i_clk);
      `CHK("continuity loss up", 1'b0, egr_down)
      rmep_ok <= 1'b1;
      finish_test();
   end

   // run is about 60000 cycles
   initial
   begin
      #2000000;
      errors++;
      finish_test();
   end
endmodule
